/* dv/cap_sense_cmp_asserts.sv */
// assertions for the threshold comparator
`timescale 1ns/1ps
module cmp_chk (
    input wire clk, rst_n, conv_done, greater_than_irq_enable,
    input wire greater_than_flag, cmp_irq, scan_hold, wake_req,
    input wire suspend_active,
    input wire [15:0] conv_result,
    input wire [6:0] acc_count,
    input wire [7:0] sense_threshold_high, sense_threshold_low);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire gt = conv_result > {sense_threshold_high, sense_threshold_low};
    sequence s_fin; conv_done && acc_count < 2; endsequence
    sequence s_gt; s_fin ##0 gt; endsequence
    a_flag_set: assert property (s_gt |=> greater_than_flag)
        else $error("set");
    a_flag_clear: assert property (s_fin ##0 !gt |=> !greater_than_flag)
        else $error("clear");
    a_flag_keep: assert property (!conv_done |=>
        $stable(greater_than_flag)) else $error("keep");
    a_irq_raise: assert property (s_gt ##0 greater_than_irq_enable
        |=> cmp_irq) else $error("irq");
    a_irq_cause: assert property (cmp_irq |->
        greater_than_flag && $past(greater_than_irq_enable)) else $error("x");
    a_hold_cause: assert property ($rose(scan_hold) |-> greater_than_flag)
        else $error("hold");
    a_wake_cause: assert property (wake_req |-> greater_than_flag)
        else $error("wake");
    a_flag_rise: assert property ($rose(greater_than_flag) |-> $past(gt))
        else $error("rise");
    a_wake_raise: assert property (s_gt ##0 suspend_active
        |=> wake_req) else $error("wake raise");
endmodule
bind cap_sense_threshold_compare cmp_chk chk_u (.*);

/* dv/cap_sense_threshold_compare_tb_top.sv */
// bench for the threshold comparator
`timescale 1ns/1ps
module cap_sense_threshold_compare_tb_top;
    reg clk = 0, rst_n = 0, conv_done = 0, auto_scan_en = 1;
    reg suspend_active = 0, greater_than_irq_enable = 1;
    reg sense_busy_write_one = 0, thr_high_wr = 0, thr_low_wr = 0;
    reg [15:0] conv_result = 0;
    reg [6:0] acc_count = 0;
    reg [7:0] thr_wdata = 0;
    wire [7:0] sense_threshold_high, sense_threshold_low;
    wire greater_than_flag, cmp_irq, scan_hold, wake_req;
    integer miscompares = 0, num_checks = 0;
    cap_sense_threshold_compare dut_u (.*);
    task chk(input [23:0] nm, input [15:0] seen, exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s %h %h", nm, exp, seen);
        end
    endtask
    // exp is {wake, irq, hold, flag}
    task conv(input [15:0] r, input [3:0] exp);
        @(negedge clk) {conv_result, conv_done} = {r, 1'b1};
        @(negedge clk) conv_done = 0;
        chk("out", {wake_req, cmp_irq, scan_hold, greater_than_flag}, exp);
    endtask
    task print_verdict;
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial forever #2.5 clk = ~clk;
    initial begin
        #1000 miscompares = miscompares + 1;
        print_verdict;
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1;
        chk("thr", {sense_threshold_high, sense_threshold_low}, 0);
        @(negedge clk) {thr_low_wr, thr_high_wr, thr_wdata} = 10'h234;
        @(negedge clk) {thr_low_wr, thr_high_wr, thr_wdata} = 10'h112;
        @(negedge clk) thr_high_wr = 0;
        chk("thr", {sense_threshold_high, sense_threshold_low}, 16'h1234);
        conv(16'h1234, 4'h0);
        conv(16'h1235, 4'h7);
        conv(16'h0000, 4'h2);
        @(negedge clk) sense_busy_write_one = 1;
        @(negedge clk) sense_busy_write_one = 0;
        {acc_count, suspend_active, greater_than_irq_enable} = 9'h00e;
        conv(16'hffff, 4'h0);
        conv(16'hffff, 4'h0);
        conv(16'hffff, 4'hb);
        repeat (2) @(negedge clk);
        sense_busy_write_one = 1;
        @(negedge clk) sense_busy_write_one = 0;
        chk("hld", scan_hold, 0);
        print_verdict;
    end
endmodule

/* rtl/cap_sense_cmp_defs.vh */
// constants for the capacitive-sense threshold comparator
// Overview of operation
// - compare latest result against high:low threshold
// - result at or below threshold clears flag
// - result above threshold sets flag
// - with accumulation, compare only final conversion
// - flag set raises interrupt when enable set
// - flag during auto-scan halts scans until busy written
// - suspended device wakes on greater-than event
// - wake-up happens even with interrupt disabled
`ifndef CAP_SENSE_CMP_DEFS_VH
`define CAP_SENSE_CMP_DEFS_VH
`define THR_RESET 8'h00
`define FLAG_RESET 1'b0
`define ACC_CNT_RESET 7'h00
`define ONE_CNT 7'h01
`define BIT_SET 1'b1
`define BIT_CLR 1'b0
`endif

/* rtl/cap_sense_threshold_compare.v */
// threshold comparator following a capacitive-sense converter
`timescale 1ns/1ps
`include "cap_sense_cmp_defs.vh"
module cap_sense_threshold_compare #(
    parameter RES_W = 16,
    parameter ACC_W = 7
) (
    input wire clk,
    input wire rst_n,
    input wire [RES_W-1:0] conv_result,
    input wire conv_done,
    input wire [ACC_W-1:0] acc_count,
    input wire auto_scan_en,
    input wire suspend_active,
    input wire greater_than_irq_enable,
    input wire sense_busy_write_one,
    input wire thr_high_wr,
    input wire thr_low_wr,
    input wire [7:0] thr_wdata,
    output reg [7:0] sense_threshold_high,
    output reg [7:0] sense_threshold_low,
    output reg greater_than_flag,
    output reg cmp_irq,
    output reg scan_hold,
    output reg wake_req
);
    // ==================================================================
    // threshold registers
    // ==================================================================
    wire [7:0] thr_high_w;
    wire [7:0] thr_low_w;
    threshold_store u_store (
        .clk(clk),
        .rst_n(rst_n),
        .wr_high(thr_high_wr),
        .wr_low(thr_low_wr),
        .wdata(thr_wdata),
        .thr_high_q(thr_high_w),
        .thr_low_q(thr_low_w)
    );
    always @* begin
        sense_threshold_high = thr_high_w;
        sense_threshold_low = thr_low_w;
    end

    // ==================================================================
    // comparison against the threshold pair
    // ==================================================================
    wire [15:0] threshold;
    wire [RES_W-1:0] thr_ext;
    wire above;

    // high byte on top, low byte below
    assign threshold = {thr_high_w, thr_low_w};
    assign thr_ext = threshold[RES_W-1:0];
    // unsigned compare; equal counts as not above
    assign above = conv_result > thr_ext;

    // ==================================================================
    // accumulation counting
    // ==================================================================
    reg [ACC_W-1:0] acc_cnt_q;
    reg [ACC_W-1:0] acc_cnt_d;
    reg [ACC_W-1:0] acc_cnt_inc;
    reg final_conv;

    // a set of 0 or 1 conversions compares on every conversion
    always @* begin
        acc_cnt_inc = acc_cnt_q + `ONE_CNT;
        acc_cnt_d = acc_cnt_q;
        final_conv = `BIT_CLR;
        if (conv_done) begin
            if (acc_cnt_inc >= acc_count) begin
                final_conv = `BIT_SET;
                acc_cnt_d = `ACC_CNT_RESET;
            end else begin
                acc_cnt_d = acc_cnt_inc;
            end
        end
    end

    // counter restarts after the last conversion of a set
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_cnt_q <= `ACC_CNT_RESET;
        end else begin
            acc_cnt_q <= acc_cnt_d;
        end
    end

    // ==================================================================
    // comparator events
    // ==================================================================
    wire cmp_event;
    wire gt_event;

    // intermediate conversions of a set raise no event
    assign cmp_event = final_conv;
    assign gt_event = final_conv && above;

    // ==================================================================
    // qualified causes
    // ==================================================================
    wire irq_cause;
    wire hold_cause;
    wire wake_cause;

    // the interrupt enable gates the request only
    assign irq_cause = gt_event && greater_than_irq_enable;
    // a hold only matters while auto-scan is running
    assign hold_cause = gt_event && auto_scan_en;
    // suspend wake ignores the interrupt enable
    assign wake_cause = gt_event && suspend_active;

    // ==================================================================
    // greater-than flag
    // ==================================================================
    reg flag_q;
    reg flag_d;

    // only a completed comparison may move the flag
    always @* begin
        flag_d = flag_q;
        if (cmp_event) begin
            if (above) begin
                flag_d = `BIT_SET;
            end else begin
                flag_d = `BIT_CLR;
            end
        end
    end

    // flag state register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= `FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ==================================================================
    // interrupt request pulse
    // ==================================================================
    reg irq_q;
    reg irq_d;

    // one-cycle pulse per greater-than event while the interrupt enable is set
    always @* begin
        irq_d = `BIT_CLR;
        if (irq_cause) begin
            irq_d = `BIT_SET;
        end
    end

    // interrupt pulse register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= `FLAG_RESET;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ==================================================================
    // auto-scan hold
    // ==================================================================
    reg hold_q;
    reg hold_d;

    // a new event wins over a busy write in the same cycle
    always @* begin
        hold_d = hold_q;
        if (hold_cause) begin
            hold_d = `BIT_SET;
        end else if (sense_busy_write_one) begin
            hold_d = `BIT_CLR;
        end
    end

    // hold state register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= `FLAG_RESET;
        end else begin
            hold_q <= hold_d;
        end
    end

    // ==================================================================
    // suspend wake request
    // ==================================================================
    reg wake_q;
    reg wake_d;

    // one-cycle pulse while suspended
    always @* begin
        wake_d = `BIT_CLR;
        if (wake_cause) begin
            wake_d = `BIT_SET;
        end
    end

    // wake pulse register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= `FLAG_RESET;
        end else begin
            wake_q <= wake_d;
        end
    end

    // ==================================================================
    // outputs
    // ==================================================================
    // every output is a plain copy of a register
    always @* begin
        greater_than_flag = flag_q;
        cmp_irq = irq_q;
        scan_hold = hold_q;
        wake_req = wake_q;
    end
endmodule

/* rtl/threshold_store.v */
// threshold byte pair storage with registered read data
`timescale 1ns/1ps
`include "cap_sense_cmp_defs.vh"
module threshold_store (
    input wire clk,
    input wire rst_n,
    input wire wr_high,
    input wire wr_low,
    input wire [7:0] wdata,
    output reg [7:0] thr_high_q,
    output reg [7:0] thr_low_q
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_high_q <= `THR_RESET;
            thr_low_q <= `THR_RESET;
        end else begin
            if (wr_high) begin
                thr_high_q <= wdata;
            end
            if (wr_low) begin
                thr_low_q <= wdata;
            end
        end
    end
endmodule
